// *** hdl/ampc_pkg.sv ***
package ampc_pkg;
  // Input mode field codes (three-bit field).
  localparam logic [2:0] MODE_16 = 3'h0;
  localparam logic [2:0] MODE_32 = 3'h1;
  localparam logic [2:0] MODE_8 = 3'h2;
  // Resolution field codes.
  localparam logic [1:0] RES_10 = 2'h0;
  localparam logic [1:0] RES_12 = 2'h1;
  localparam logic [1:0] RES_14 = 2'h2;
  // Serialization factor codes.
  localparam logic [1:0] SER_10 = 2'h0;
  localparam logic [1:0] SER_12 = 2'h1;
  localparam logic [1:0] SER_14 = 2'h2;
  localparam logic [1:0] SER_16 = 2'h3;
  // Number of converters and reset values.
  localparam int NUM_CONV = 16;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [1:0] RES_RESET = 2'h0;
  localparam logic [1:0] SER_RESET = 2'h0;
  // Largest conversion clock per resolution, in MHz.
  localparam int FC_MAX_10_MHZ = 100;
  localparam int FC_MAX_12_MHZ = 80;
  localparam int FC_MAX_14_MHZ = 65;
  // Controller register offsets.
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_POWER = 4'h1;
  localparam logic [3:0] REG_ANA_OFF = 4'h2;
  localparam logic [3:0] REG_DIG_OFF = 4'h3;
  localparam logic [3:0] REG_LANE_OFF = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_APPLY = 4'h6;
  // Config word field positions.
  localparam int F_MODE = 0;
  localparam int F_RES = 4;
  localparam int F_SER = 8;
  localparam int F_DBL = 12;
  localparam int F_LDIS = 13;
  localparam int F_JEN = 14;
  // Status word field positions.
  localparam int S_ERR = 0;
  localparam int S_BUSY = 1;
  localparam int S_GPD = 2;
  localparam int S_STBY = 3;
  localparam int S_LANES = 4;
  localparam int S_CLKL = 5;

  // Checks one full configuration against the legal mode table.
  function automatic logic ampc_legal(input logic [2:0] mode,
                                      input logic [1:0] res,
                                      input logic dbl, input logic jen);
    logic ok;
    ok = 1'b0;
    unique case (mode)
      MODE_16: ok = (res != 2'h3);
      MODE_32: ok = (res != 2'h3) && !dbl;
      MODE_8: ok = (res == RES_10) && !jen;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Converter clock limit in MHz for a resolution code.
  function automatic int ampc_fc_max(input logic [1:0] res);
    int f;
    f = 0;
    unique case (res)
      RES_10: f = FC_MAX_10_MHZ;
      RES_12: f = FC_MAX_12_MHZ;
      RES_14: f = FC_MAX_14_MHZ;
      default: f = 0;
    endcase
    return f;
  endfunction
endpackage

// *** hdl/ampc_if.sv ***
`timescale 1ns/1ps
// Configuration serial-interface side and the control pins between ends.
interface ampc_if (
  input wire logic clock,
  input wire logic rst_n
);
  logic cfg_write;
  logic [2:0] cfg_mode;
  logic [1:0] cfg_res;
  logic [1:0] cfg_ser;
  logic cfg_dbl;
  logic cfg_ldis;
  logic cfg_jen;
  logic cfg_gpd_bit;
  logic [15:0] cfg_ana_off;
  logic [15:0] cfg_dig_off;
  logic [15:0] cfg_lane_off;
  logic global_powerdown_pin;
  logic standby_pin;
  logic dev_error;
  logic dev_global_down;
  logic dev_standby;
  logic dev_data_lanes_on;
  logic dev_clock_lanes_on;
  modport device (
    input clock, rst_n, cfg_write, cfg_mode, cfg_res, cfg_ser, cfg_dbl,
    input cfg_ldis, cfg_jen, cfg_gpd_bit, cfg_ana_off, cfg_dig_off,
    input cfg_lane_off, global_powerdown_pin, standby_pin,
    output dev_error, dev_global_down, dev_standby, dev_data_lanes_on,
    output dev_clock_lanes_on
  );
  modport host (
    input clock, rst_n, dev_error, dev_global_down, dev_standby,
    input dev_data_lanes_on, dev_clock_lanes_on,
    output cfg_write, cfg_mode, cfg_res, cfg_ser, cfg_dbl, cfg_ldis,
    output cfg_jen, cfg_gpd_bit, cfg_ana_off, cfg_dig_off, cfg_lane_off,
    output global_powerdown_pin, standby_pin
  );
endinterface

// *** hdl/ampc_host.sv ***
`timescale 1ns/1ps
// Receiving-side controller: holds a configuration from software, refuses
// illegal sets, drives the power pins and reports device status.
module ampc_host (
  input wire logic clock,
  input wire logic rst_n,
  ampc_if.host link,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  import ampc_pkg::*;

  // Whole state of the controller.
  typedef struct packed {
    logic [15:0] cfg;
    logic gpd_bit;
    logic gpd_pin;
    logic stby_pin;
    logic [15:0] ana;
    logic [15:0] dig;
    logic [15:0] lane;
    logic write;
    logic refused;
    logic [31:0] rdata;
  } ampc_host_s;

  ampc_host_s st;
  ampc_host_s next_st;
  logic [31:0] status_word;

  // Status as software sees it.
  always_comb begin
    status_word = '0;
    status_word[S_ERR] = link.dev_error | st.refused;
    status_word[S_BUSY] = st.write;
    status_word[S_GPD] = link.dev_global_down;
    status_word[S_STBY] = link.dev_standby;
    status_word[S_LANES] = link.dev_data_lanes_on;
    status_word[S_CLKL] = link.dev_clock_lanes_on;
  end

  // Register writes and reads; apply sends a config only when legal.
  always_comb begin
    next_st = st;
    next_st.write = 1'b0;
    next_st.rdata = '0;
    if (wr) begin
      unique case (addr)
        REG_CONFIG: next_st.cfg = wdata[15:0];
        REG_POWER: begin
          next_st.gpd_bit = wdata[0];
          next_st.gpd_pin = wdata[1];
          next_st.stby_pin = wdata[2];
        end
        REG_ANA_OFF: next_st.ana = wdata[15:0];
        REG_DIG_OFF: next_st.dig = wdata[15:0];
        REG_LANE_OFF: next_st.lane = wdata[15:0];
        REG_APPLY: begin
          // Only legal sets are sent to the device.
          if (ampc_legal(st.cfg[F_MODE +: 3], st.cfg[F_RES +: 2],
                         st.cfg[F_DBL], st.cfg[F_JEN])) begin
            next_st.write = 1'b1;
          end else begin
            next_st.refused = 1'b1;
          end
        end
        REG_STATUS: next_st.refused = 1'b0;
        default: next_st.write = 1'b0;
      endcase
    end
    if (rd) begin
      unique case (addr)
        REG_CONFIG: next_st.rdata = {16'h0000, st.cfg};
        REG_POWER: next_st.rdata = {29'h0, st.stby_pin, st.gpd_pin,
                                    st.gpd_bit};
        REG_ANA_OFF: next_st.rdata = {16'h0000, st.ana};
        REG_DIG_OFF: next_st.rdata = {16'h0000, st.dig};
        REG_LANE_OFF: next_st.rdata = {16'h0000, st.lane};
        REG_STATUS: next_st.rdata = status_word;
        default: next_st.rdata = '0;
      endcase
    end
  end

  // State register with synchronous reset to a legal default.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Drive the link from registered state.
  assign link.cfg_write = st.write;
  assign link.cfg_mode = st.cfg[F_MODE +: 3];
  assign link.cfg_res = st.cfg[F_RES +: 2];
  assign link.cfg_ser = st.cfg[F_SER +: 2];
  assign link.cfg_dbl = st.cfg[F_DBL];
  assign link.cfg_ldis = st.cfg[F_LDIS];
  assign link.cfg_jen = st.cfg[F_JEN];
  assign link.cfg_gpd_bit = st.gpd_bit;
  assign link.cfg_ana_off = st.ana;
  assign link.cfg_dig_off = st.dig;
  assign link.cfg_lane_off = st.lane;
  assign link.global_powerdown_pin = st.gpd_pin;
  assign link.standby_pin = st.stby_pin;
  assign rdata = st.rdata;
endmodule

// *** hdl/ampc_device.sv ***
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - Three-bit field picks 16, 32, 8 inputs.
// - Eight-input pairs offset one system clock.
// - Eight-input mode only at 10 bits.
// - Mode, resolution and density legal table.
// - Resolution 10/12/14 sets rate limit.
// - Clock limits 100/80/65 MHz kept outside.
// - LVDS on from reset, off when disabled.
// - JESD enable bit, 16/32 modes only.
// - Serialization factor 10, 12, 14, 16.
// - Density control selects 1X or 2X.
// - Outside keeps lane rate within limit.
// - Global by pin or bit; standby pin.
// - Standby stops data lanes, keeps clocks.
// - Global power-down stops every lane.
// - Band-gap and interface never powered down.
// - Standby and per-channel section power-down.
module ampc_device (
  input wire logic clock,
  input wire logic rst_n,
  ampc_if.device link,
  output logic [2:0] input_mode_select,
  output logic [1:0] converter_resolution,
  output logic [1:0] serialization_factor,
  output logic [4:0] serial_bits,
  output logic payload_density_double,
  output logic lvds_output_disable,
  output logic serial_link_enable,
  output logic [6:0] fc_max_mhz,
  output logic [15:0] conv_phase,
  output logic [15:0] channel_analog_off,
  output logic [15:0] channel_digital_off,
  output logic [15:0] channel_lane_off,
  output logic [15:0] data_lane_on,
  output logic clock_lanes_on,
  output logic reference_on,
  output logic pll_on,
  output logic bandgap_on,
  output logic config_port_on,
  output logic config_error
);
  import ampc_pkg::*;

  // Power states of the whole device.
  typedef enum logic [1:0] {PWR_ACTIVE, PWR_STANDBY, PWR_GLOBAL}
    ampc_pwr_e;

  // Whole state of the device.
  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] res;
    logic [1:0] ser;
    logic dbl;
    logic ldis;
    logic jen;
    logic gpd_bit;
    logic [15:0] ana;
    logic [15:0] dig;
    logic [15:0] lane;
    logic err;
    logic phase;
    ampc_pwr_e pwr;
  } ampc_dev_s;

  ampc_dev_s st;
  ampc_dev_s next_st;
  logic req_legal;
  logic [15:0] data_on;

  // Decodes serialization code to bits per word.
  function automatic logic [4:0] ser_bits(input logic [1:0] code);
    logic [4:0] b;
    b = 5'h0a;
    unique case (code)
      SER_10: b = 5'h0a;
      SER_12: b = 5'h0c;
      SER_14: b = 5'h0e;
      SER_16: b = 5'h10;
    endcase
    return b;
  endfunction

  // Legality of the incoming set, checked by the device too.
  assign req_legal = ampc_legal(link.cfg_mode, link.cfg_res,
                                link.cfg_dbl, link.cfg_jen);

  // Next-state logic: config loading, error flag and power state.
  always_comb begin
    next_st = st;
    // Conversion phase toggles every system clock.
    next_st.phase = ~st.phase;
    if (link.cfg_write) begin
      next_st.mode = link.cfg_mode;
      next_st.res = link.cfg_res;
      next_st.ser = link.cfg_ser;
      next_st.dbl = link.cfg_dbl;
      next_st.ldis = link.cfg_ldis;
      // JESD only allowed in the 16 and 32 input modes.
      next_st.jen = link.cfg_jen && (link.cfg_mode != MODE_8);
      next_st.ana = link.cfg_ana_off;
      next_st.dig = link.cfg_dig_off;
      next_st.lane = link.cfg_lane_off;
      if (!req_legal) begin
        next_st.err = 1'b1;
      end
    end
    next_st.gpd_bit = link.cfg_gpd_bit;
    // Global wins over standby; pin or bit may request it.
    if (link.global_powerdown_pin || link.cfg_gpd_bit) begin
      next_st.pwr = PWR_GLOBAL;
    end else if (link.standby_pin) begin
      next_st.pwr = PWR_STANDBY;
    end else begin
      next_st.pwr = PWR_ACTIVE;
    end
  end

  // State register; LVDS comes out of reset enabled.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '{mode: MODE_RESET, res: RES_RESET, ser: SER_RESET,
              dbl: 1'b0, ldis: 1'b0, jen: 1'b0, gpd_bit: 1'b0,
              ana: 16'h0000, dig: 16'h0000, lane: 16'h0000,
              err: 1'b0, phase: 1'b0, pwr: PWR_ACTIVE};
    end else begin
      st <= next_st;
    end
  end

  // Per-lane data enable: off in any power-down, on disable, or per lane.
  genvar g;
  generate
    for (g = 0; g < NUM_CONV; g++) begin : g_lane
      assign data_on[g] = (st.pwr == PWR_ACTIVE) && !st.ldis &&
                          !st.lane[g];
      // Odd converter of a pair runs one clock later in eight-input mode.
      assign conv_phase[g] = (st.mode == MODE_8 && g % 2 == 1) ?
                             ~st.phase : st.phase;
    end
  endgenerate

  // Outputs; clocks stay up in standby, down in global power-down.
  assign data_lane_on = data_on;
  assign clock_lanes_on = (st.pwr != PWR_GLOBAL) &&
                          !st.ldis;
  assign reference_on = (st.pwr != PWR_GLOBAL);
  assign pll_on = (st.pwr != PWR_GLOBAL);
  assign bandgap_on = 1'b1;
  assign config_port_on = 1'b1;
  assign channel_analog_off = (st.pwr != PWR_ACTIVE) ? 16'hffff : st.ana;
  assign channel_digital_off = (st.pwr != PWR_ACTIVE) ? 16'hffff : st.dig;
  assign channel_lane_off = ~data_on;
  assign input_mode_select = st.mode;
  assign converter_resolution = st.res;
  assign serialization_factor = st.ser;
  assign serial_bits = ser_bits(st.ser);
  assign payload_density_double = st.dbl;
  assign lvds_output_disable = st.ldis;
  assign serial_link_enable = st.jen;
  assign fc_max_mhz = 7'(ampc_fc_max(st.res));
  assign config_error = st.err;
  assign link.dev_error = st.err;
  assign link.dev_global_down = (st.pwr == PWR_GLOBAL);
  assign link.dev_standby = (st.pwr == PWR_STANDBY);
  assign link.dev_data_lanes_on = |data_on;
  assign link.dev_clock_lanes_on = clock_lanes_on;
endmodule

// *** sim/ampc_asserts.sv ***
`timescale 1ns/1ps
// Watches the link between the controller and the device.
module ampc_asserts
  import ampc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cfg_write,
  input wire logic [2:0] cfg_mode,
  input wire logic [1:0] cfg_res,
  input wire logic cfg_dbl,
  input wire logic cfg_ldis,
  input wire logic cfg_jen,
  input wire logic cfg_gpd_bit,
  input wire logic global_powerdown_pin,
  input wire logic standby_pin,
  input wire logic dev_error,
  input wire logic dev_global_down,
  input wire logic dev_standby,
  input wire logic dev_data_lanes_on,
  input wire logic dev_clock_lanes_on
);
  // Lane-disable value most recently loaded into the device.
  logic ldis_q;
  // Follows each load so lane checks know the disable setting.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ldis_q <= 1'b0;
    end else if (cfg_write) begin
      ldis_q <= cfg_ldis;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // A power-down request from the pin or the bit.
  sequence down_req_s;
    global_powerdown_pin || cfg_gpd_bit;
  endsequence
  // A configuration load in the eight-input mode.
  sequence load8_s;
    cfg_write && (cfg_mode == MODE_8);
  endsequence
  gdown_enter_a: assert property (down_req_s |=> dev_global_down)
    else $error("global power-down not entered");
  stby_enter_a: assert property (
    standby_pin && !global_powerdown_pin && !cfg_gpd_bit
    |=> dev_standby && !dev_global_down) else $error("standby not entered");
  wake_up_a: assert property (
    !standby_pin && !global_powerdown_pin && !cfg_gpd_bit
    |=> !dev_standby && !dev_global_down) else $error("no wake-up");
  stby_lanes_a: assert property (dev_standby |-> !dev_data_lanes_on)
    else $error("data lanes run in standby");
  clock_keep_a: assert property (
    !dev_global_down && !ldis_q |-> dev_clock_lanes_on)
    else $error("clock lanes stopped");
  gdown_dark_a: assert property (
    dev_global_down |-> !dev_data_lanes_on && !dev_clock_lanes_on)
    else $error("lanes run in global power-down");
  ldis_dark_a: assert property (
    ldis_q |-> !dev_data_lanes_on && !dev_clock_lanes_on)
    else $error("lanes run while disabled");
  load8_legal_a: assert property (
    load8_s |-> cfg_res == RES_10 && !cfg_jen)
    else $error("illegal eight-input load sent");
  load32_legal_a: assert property (
    cfg_write && cfg_mode == MODE_32 |-> !cfg_dbl)
    else $error("double density sent in 32-input mode");
  no_error_a: assert property (cfg_write && !dev_error |=> !dev_error)
    else $error("error raised on a legal load");
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import ampc_pkg::*;
  // Clock, reset and the software port of the controller.
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  // Device outputs, gathered into one word for comparison.
  logic [2:0] input_mode_select;
  logic [1:0] converter_resolution, serialization_factor;
  logic [4:0] serial_bits;
  logic [6:0] fc_max_mhz;
  logic [15:0] conv_phase, data_lane_on;
  logic payload_density_double, lvds_output_disable, serial_link_enable;
  logic bandgap_on, config_port_on;
  logic [40:0] dev_word;
  // Expected results waiting for their outputs, and the counters.
  logic [63:0] rq[$];
  logic [63:0] dq[$];
  int bad_count = 0;
  int checks_done = 0;
  logic rd_d = 1'b0;
  logic w_d = 1'b0;
  // Bench copies of power state, lane disable and lane-off pattern.
  logic gd = 1'b0;
  logic sb = 1'b0;
  logic ld = 1'b0;
  logic [15:0] lo = 16'h0000;
  logic [31:0] r;
  logic [2:0] m;
  logic [1:0] rs, s;
  logic [31:0] bad[3] = '{32'h0000_0012, 32'h0000_1001, 32'h0000_4002};
  ampc_if ifa (.clock(clock), .rst_n(rst_n));
  ampc_host ampc_host_inst (.clock, .rst_n, .link(ifa), .addr, .wdata,
    .wr, .rd, .rdata);
  ampc_device ampc_device_inst (.clock, .rst_n, .link(ifa),
    .input_mode_select, .converter_resolution, .serialization_factor,
    .serial_bits, .payload_density_double, .lvds_output_disable,
    .serial_link_enable, .fc_max_mhz, .conv_phase, .channel_analog_off(),
    .channel_digital_off(), .channel_lane_off(), .data_lane_on,
    .clock_lanes_on(), .reference_on(), .pll_on(), .bandgap_on,
    .config_port_on, .config_error());
  ampc_asserts ampc_asserts_inst (.clock(ifa.clock), .rst_n(ifa.rst_n),
    .cfg_write(ifa.cfg_write), .cfg_mode(ifa.cfg_mode),
    .cfg_res(ifa.cfg_res), .cfg_dbl(ifa.cfg_dbl), .cfg_ldis(ifa.cfg_ldis),
    .cfg_jen(ifa.cfg_jen), .cfg_gpd_bit(ifa.cfg_gpd_bit),
    .global_powerdown_pin(ifa.global_powerdown_pin),
    .standby_pin(ifa.standby_pin), .dev_error(ifa.dev_error),
    .dev_global_down(ifa.dev_global_down), .dev_standby(ifa.dev_standby),
    .dev_data_lanes_on(ifa.dev_data_lanes_on),
    .dev_clock_lanes_on(ifa.dev_clock_lanes_on));
  // The phase bit is set when a converter pair runs staggered.
  assign dev_word = {input_mode_select, converter_resolution,
    serialization_factor, serial_bits, payload_density_double,
    lvds_output_disable, serial_link_enable, fc_max_mhz,
    conv_phase[1] ^ conv_phase[0], data_lane_on, bandgap_on, config_port_on};
  // Free-running 200 MHz clock.
  initial forever #2.5 clock = ~clock;
  // Compares one result and reports a mismatch at once.
  task automatic cmp(input string n, input logic [63:0] e, g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // One bus cycle, a write or a read; exactly one strobe set each cycle.
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clock);
  endtask
  // Drops both strobes and lets some cycles pass.
  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clock);
  endtask
  // Loads a configuration and notes the outputs the device must show.
  task automatic load(input logic [2:0] m, input logic [1:0] rs, s,
                      input logic db, l, jn);
    logic [15:0] on;
    on = (gd || sb || l) ? 16'h0000 : ~lo;
    ld = l;
    dq.push_back({m, rs, s, 5'(10 + 2 * s), db, l, jn,
      7'(rs == RES_10 ? FC_MAX_10_MHZ : rs == RES_12 ? FC_MAX_12_MHZ :
      FC_MAX_14_MHZ), m == MODE_8, on, 2'b11});
    bus(1'b1, REG_CONFIG, {17'h0_0000, jn, l, db, 2'h0, s, 2'h0, rs, 1'b0, m});
    bus(1'b1, REG_APPLY, 32'h0000_0000);
    idle(4);
  endtask
  // Reads the status word and notes what it must hold.
  task automatic status(input logic e);
    rq.push_back({58'h0, !(gd || ld), !(gd || sb || ld) && lo != 16'hFFFF,
      sb, gd, 1'b0, e});
    bus(1'b0, REG_STATUS, 32'h0000_0000);
    idle(1);
  endtask
  // Takes the oldest note off a queue whenever its result appears.
  always @(posedge clock) begin
    if (rd_d) cmp("rdata", rq.pop_front(), 64'(rdata));
    if (w_d) cmp("device", dq.pop_front(), 64'(dev_word));
    rd_d <= rd;
    w_d <= ifa.cfg_write;
  end
  // Main sequence.
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    void'($urandom(87));
    status(1'b0);
    rq.push_back(64'h0);
    bus(1'b0, 4'hF, 32'h0000_0000);
    rq.push_back(64'h0);
    bus(1'b0, REG_CONFIG, 32'h0000_0000);
    idle(1);
    // Every mode, resolution and factor first, then random legal sets.
    for (int i = 0; i < 40; i++) begin
      r = (i < 12) ? i : $urandom;
      m = 3'(r % 3);
      rs = (m == MODE_8) ? RES_10 : 2'((r / 4) % 3);
      s = 2'((r / 3) % 4);
      load(m, rs, s, r[5] && m != MODE_32, r[4] && i > 11,
           r[6] && m != MODE_8);
    end
    // Illegal sets are refused and never reach the device.
    foreach (bad[k]) begin
      bus(1'b1, REG_CONFIG, bad[k]);
      bus(1'b1, REG_APPLY, 32'h0000_0000);
      idle(3);
      status(1'b1);
      bus(1'b1, REG_STATUS, 32'h0000_0000);
      status(1'b0);
    end
    // Every power request, with random lanes switched off per channel.
    for (int p = 0; p < 9; p++) begin
      lo = (p == 8) ? 16'hFFFF : 16'($urandom);
      bus(1'b1, REG_LANE_OFF, {16'h0000, lo});
      bus(1'b1, REG_POWER, 32'(p & 7));
      gd = p[0] || p[1];
      sb = p[2] && !gd;
      idle(3);
      load(MODE_16, RES_14, SER_16, 1'b1, 1'b0, 1'b1);
      status(1'b0);
    end
    idle(2);
    cmp("pending", 64'h0, 64'(rq.size() + dq.size()));
    end_sim;
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    end_sim;
  end
endmodule
